// ---- uart_block_transfer_engine_bench.sv ----
// Purpose: self-checking bench for the serial block-transfer engine
// Assumes: apb answers with one wait state, bit time from the package
// Notes:   blocks kept to two bytes, a full 256-byte block would take millions of cycles
`timescale 1ns/1ns
module uart_block_transfer_engine_bench;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        serial_in_pin;
  logic        start_switch_line;
  logic        serial_out_pin;
  logic [31:0] rd;
  logic        err;
  int          mismatches = 0;
  int          checks_done = 0;

  ubt_engine dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(serial_in_pin), .start_switch_line(start_switch_line),
    .serial_out_pin(serial_out_pin));
  ubt_peer peer (.clk(clk), .line_in(serial_out_pin), .line_out(serial_in_pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // an idle edge first, so psel is never lowered and raised in one time step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk("pready", 32'h1, 32'h0);
  endtask

  task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  task automatic wait_rx(input int k);
    int n;
    for (n = 0; n < 30000 && peer.got.size() < k; n++) @(posedge clk);
    chk("peer frames", k, peer.got.size());
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic t_reset();
    chk("serial_out idle", 32'h1, serial_out_pin);
    rdc("ctrl reset", ubt_pkg::CTRL_ADDR, 32'h0);
    rdc("unmapped data", 12'h100, 32'h0);
    chk("unmapped pslverr", 32'h1, err);
    $display("test reset done");
  endtask

  task automatic t_start();
    apb(1'b0, ubt_pkg::STAT_ADDR, 32'h0);
    chk("start before edge", 32'h0, rd[ubt_pkg::ST_START]);
    start_switch_line <= 1'b0;
    repeat (8) @(posedge clk);
    apb(1'b0, ubt_pkg::STAT_ADDR, 32'h0);
    chk("start seen", 32'h1, rd[ubt_pkg::ST_START]);
    apb(1'b1, ubt_pkg::STAT_ADDR, 32'h10);
    apb(1'b0, ubt_pkg::STAT_ADDR, 32'h0);
    chk("start cleared", 32'h0, rd[ubt_pkg::ST_START]);
    start_switch_line <= 1'b1;
    $display("test start edge done");
  endtask

  task automatic t_xfer();
    int n;
    apb(1'b1, 12'h440, 32'ha5);
    apb(1'b1, 12'h444, 32'h3c);
    apb(1'b1, ubt_pkg::TXD_ADDR, 32'h8000_0210);
    apb(1'b1, ubt_pkg::RXD_ADDR, 32'h8000_0120);
    rdc("tx desc idle", ubt_pkg::TXD_ADDR, 32'h8000_0210);
    fork
      peer.send(8'h5a, 1'b1);
    join_none
    apb(1'b1, ubt_pkg::CTRL_ADDR, 32'h3f);
    repeat (10) @(posedge clk);
    rdc("tx desc", ubt_pkg::TXD_ADDR, 32'h8000_0012);
    apb(1'b0, ubt_pkg::STAT_ADDR, 32'h0);
    chk("tx pending mid-frame", 32'h0, rd[ubt_pkg::ST_TXE]);
    apb(1'b0, ubt_pkg::HOLD_ADDR, 32'h0);
    chk("tx holding", 32'h3c, rd[7:0]);
    wait_rx(1);
    // the peer reports at mid stop bit; the next load only comes at the stop bit's end
    repeat (1400) @(posedge clk);
    apb(1'b0, ubt_pkg::STAT_ADDR, 32'h0);
    chk("tx pending kept", 32'h1, rd[ubt_pkg::ST_TXE]);
    wait_rx(2);
    chk("byte 0", 32'ha5, peer.got[0]);
    chk("byte 1", 32'h3c, peer.got[1]);
    chk("stop errors", 32'h0, peer.stop_errs);
    apb(1'b1, ubt_pkg::CTRL_ADDR, 32'h3e);
    n = 0;
    do begin
      apb(1'b0, ubt_pkg::STAT_ADDR, 32'h0);
      n++;
    end while (rd[ubt_pkg::ST_TEND] !== 1'b1 && n < 1000);
    chk("tx end", 32'h1, rd[ubt_pkg::ST_TEND]);
    chk("line idle", 32'h1, serial_out_pin);
    apb(1'b1, ubt_pkg::CTRL_ADDR, 32'h32);
    rdc("rx buffer", 12'h880, 32'h5a);
    rdc("rx desc", ubt_pkg::RXD_ADDR, 32'h8000_0021);
    $display("test exchange done");
  endtask

  task automatic t_rxerr();
    peer.send(8'hc3, 1'b0);
    repeat (20) @(posedge clk);
    apb(1'b0, ubt_pkg::STAT_ADDR, 32'h0);
    chk("rx error", 32'h1, rd[ubt_pkg::ST_RERR]);
    apb(1'b0, ubt_pkg::HOLD_ADDR, 32'h0);
    chk("rx holding kept", 32'h5a, rd[15:8]);
    apb(1'b1, ubt_pkg::STAT_ADDR, 32'h8);
    apb(1'b0, ubt_pkg::STAT_ADDR, 32'h0);
    chk("rx error cleared", 32'h0, rd[ubt_pkg::ST_RERR]);
    apb(1'b1, ubt_pkg::CTRL_ADDR, 32'h0);
    $display("test rx error done");
  endtask

  // two frames plus a tail plus one more frame stay well below this span
  initial begin
    repeat (95000) @(posedge clk);
    mismatches++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    start_switch_line = 1'b1;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_start();
    t_xfer();
    t_rxerr();
    stop_test();
  end
endmodule

// ---- ubt_engine.sv ----
// Purpose: uart with a request-driven block-transfer engine and two 256-byte buffers
// Assumes: serial lines and start line are asynchronous, APB master on clk
// Notes:   buffers are reached one byte per word over APB
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module ubt_engine (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial and start lines
  input  wire logic        serial_in_pin,
  input  wire logic        start_switch_line,
  output logic             serial_out_pin
);
  logic [7:0]            tx_mem [256];
  logic [7:0]            rx_mem [256];
  ubt_pkg::ubt_ctrl_t    ctrl_reg;
  ubt_pkg::ubt_desc_t    txd_reg;
  ubt_pkg::ubt_desc_t    rxd_reg;
  logic [ubt_pkg::ST_W-1:0] stat_reg;
  logic [7:0]            tx_holding_reg;
  logic                  hold_full_reg;
  logic [9:0]            tx_shift_reg;
  logic [3:0]            tx_bits_reg;
  logic [11:0]           tx_baud_reg;
  logic                  tx_busy_reg;
  logic [7:0]            rx_shift_reg;
  logic [7:0]            rx_holding_reg;
  logic [3:0]            rx_bits_reg;
  logic [11:0]           rx_baud_reg;
  ubt_pkg::ubt_rx_state_t rx_st_reg;
  logic [1:0]            rxd_sync_reg;
  logic [2:0]            sw_sync_reg;

  // bus decode
  wire        wr_en    = psel & penable & pready & pwrite;
  wire        rd_cap   = psel & penable & ~pready;
  wire [1:0]  area     = paddr[11:10];
  wire [7:0]  bidx     = paddr[9:2];
  wire        is_buf   = (area == ubt_pkg::TXBUF_SEL) | (area == ubt_pkg::RXBUF_SEL);
  wire        is_reg   = (area == 2'h0) & (paddr[9:0] <= ubt_pkg::HOLD_ADDR[9:0]) & (paddr[1:0] == 2'h0);
  wire        hit      = is_reg | (is_buf & paddr[1:0] == 2'h0);
  wire        wr_ctrl  = wr_en & hit & (paddr == ubt_pkg::CTRL_ADDR);
  wire        wr_stat  = wr_en & hit & (paddr == ubt_pkg::STAT_ADDR);
  wire        wr_txd   = wr_en & hit & (paddr == ubt_pkg::TXD_ADDR);
  wire        wr_rxd   = wr_en & hit & (paddr == ubt_pkg::RXD_ADDR);
  wire        wr_txbuf = wr_en & hit & (area == ubt_pkg::TXBUF_SEL);
  wire ubt_pkg::ubt_ctrl_t ctrl_w = ubt_pkg::ubt_ctrl_t'(pwdata[5:0]);

  function automatic ubt_pkg::ubt_desc_t desc_of(input logic [31:0] d);
    desc_of.en  = d[ubt_pkg::DS_EN_BIT];
    desc_of.cnt = d[ubt_pkg::DS_CNT_LSB +: 9];
    desc_of.ptr = d[ubt_pkg::DS_PTR_LSB +: 8];
  endfunction

  function automatic logic [31:0] desc_word(input ubt_pkg::ubt_desc_t d);
    desc_word = {d.en, 6'h00, 8'h00, d.cnt, d.ptr};
  endfunction

  wire [31:0] rd_mux =
    (paddr == ubt_pkg::CTRL_ADDR) ? {26'h0, ctrl_reg} :
    (paddr == ubt_pkg::STAT_ADDR) ? {27'h0, stat_reg} :
    (paddr == ubt_pkg::TXD_ADDR)  ? desc_word(txd_reg) :
    (paddr == ubt_pkg::RXD_ADDR)  ? desc_word(rxd_reg) :
    (paddr == ubt_pkg::HOLD_ADDR) ? {16'h0, rx_holding_reg, tx_holding_reg} :
    (area == ubt_pkg::TXBUF_SEL)  ? {24'h0, tx_mem[bidx]} :
    (area == ubt_pkg::RXBUF_SEL)  ? {24'h0, rx_mem[bidx]} : 32'h0;

  // two-cycle access: pready answers in the second access cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= rd_cap;
      pslverr <= rd_cap & ~hit;
      if (rd_cap) begin
        prdata <= hit ? rd_mux : 32'h0;
      end
    end
  end

  // transfer engine: each request steps only its own descriptor, never a chain
  wire tx_req  = stat_reg[ubt_pkg::ST_TXE] & ctrl_reg.tx_empty_int_enable & ctrl_reg.transmitter_on;
  wire tx_go   = tx_req & txd_reg.en & (txd_reg.cnt != 9'h0) & ~wr_txd;
  wire rx_req  = stat_reg[ubt_pkg::ST_RXF] & ctrl_reg.rx_full_int_enable;
  wire rx_go   = rx_req & rxd_reg.en & (rxd_reg.cnt != 9'h0) & ~wr_rxd;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txd_reg <= '0;
      rxd_reg <= '0;
    end else begin
      if (wr_txd) begin
        txd_reg <= desc_of(pwdata);
      end else if (tx_go) begin
        txd_reg.ptr <= txd_reg.ptr + 8'h01;
        txd_reg.cnt <= txd_reg.cnt - 9'h001;
      end
      if (wr_rxd) begin
        rxd_reg <= desc_of(pwdata);
      end else if (rx_go) begin
        rxd_reg.ptr <= rxd_reg.ptr + 8'h01;
        rxd_reg.cnt <= rxd_reg.cnt - 9'h001;
      end
    end
  end

  // buffers carry no reset
  always_ff @(posedge clk) begin
    if (wr_txbuf) begin
      tx_mem[bidx] <= pwdata[7:0];
    end
    if (rx_go) begin
      rx_mem[rxd_reg.ptr] <= rx_holding_reg;
    end
  end

  // transmitter
  wire tx_tick  = (tx_baud_reg == 12'h0);
  wire tx_last  = tx_busy_reg & tx_tick & (tx_bits_reg == 4'h1);
  wire tx_load  = ctrl_reg.transmitter_on & hold_full_reg & (~tx_busy_reg | tx_last);
  wire tx_end   = tx_last & ~hold_full_reg;
  wire te_rise  = wr_ctrl & ctrl_w.tx_empty_int_enable & ctrl_w.transmitter_on &
                  ~(ctrl_reg.tx_empty_int_enable & ctrl_reg.transmitter_on);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_holding_reg <= 8'h00;
      hold_full_reg  <= 1'b0;
      tx_shift_reg   <= 10'h3ff;
      tx_bits_reg    <= 4'h0;
      tx_baud_reg    <= 12'h0;
      tx_busy_reg    <= 1'b0;
      serial_out_pin <= 1'b1;
    end else begin
      if (tx_go) begin
        tx_holding_reg <= tx_mem[txd_reg.ptr];
        hold_full_reg  <= 1'b1;
      end else if (tx_load) begin
        hold_full_reg  <= 1'b0;
      end
      if (tx_load) begin
        tx_shift_reg <= {1'b1, tx_holding_reg, 1'b0};
        tx_bits_reg  <= ubt_pkg::FRAME_BITS;
        tx_baud_reg  <= ubt_pkg::BIT_CYC - 12'h1;
        tx_busy_reg  <= 1'b1;
        serial_out_pin <= 1'b0;
      end else if (tx_busy_reg) begin
        if (tx_tick) begin
          tx_baud_reg  <= ubt_pkg::BIT_CYC - 12'h1;
          tx_bits_reg  <= tx_bits_reg - 4'h1;
          tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
          serial_out_pin <= (tx_bits_reg == 4'h1) ? 1'b1 : tx_shift_reg[1];
          tx_busy_reg  <= (tx_bits_reg != 4'h1);
        end else begin
          tx_baud_reg <= tx_baud_reg - 12'h1;
        end
      end else begin
        serial_out_pin <= 1'b1;
      end
    end
  end

  // receiver and start line synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_sync_reg <= 2'b11;
      sw_sync_reg  <= 3'b111;
    end else begin
      rxd_sync_reg <= {rxd_sync_reg[0], serial_in_pin};
      sw_sync_reg  <= {sw_sync_reg[1:0], start_switch_line};
    end
  end

  localparam ubt_pkg::ubt_rx_state_t RX_DATA_S = ubt_pkg::RX_DATA;
  wire rxd     = rxd_sync_reg[1];
  wire sw_fall = sw_sync_reg[2] & ~sw_sync_reg[1];
  wire rx_tick = (rx_baud_reg == 12'h0);
  wire rx_done = (rx_st_reg == RX_DATA_S) & rx_tick & (rx_bits_reg == 4'h0);
  wire rx_good = rx_done & rxd;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_reg      <= ubt_pkg::RX_IDLE;
      rx_shift_reg   <= 8'h00;
      rx_holding_reg <= 8'h00;
      rx_bits_reg    <= 4'h0;
      rx_baud_reg    <= 12'h0;
    end else begin
      if (!rx_tick) begin
        rx_baud_reg <= rx_baud_reg - 12'h1;
      end
      unique case (rx_st_reg)
        ubt_pkg::RX_IDLE: begin
          if (ctrl_reg.rx_on & ~rxd) begin
            rx_st_reg   <= ubt_pkg::RX_START;
            rx_baud_reg <= ubt_pkg::HALF_CYC; // sample mid-bit
          end
        end
        ubt_pkg::RX_START: begin
          if (rx_tick) begin
            rx_st_reg   <= rxd ? ubt_pkg::RX_IDLE : ubt_pkg::RX_DATA; // glitch rejected
            rx_bits_reg <= ubt_pkg::DATA_BITS;
            rx_baud_reg <= ubt_pkg::BIT_CYC - 12'h1;
          end
        end
        ubt_pkg::RX_DATA: begin
          if (rx_tick) begin
            rx_baud_reg <= ubt_pkg::BIT_CYC - 12'h1;
            if (rx_bits_reg == 4'h0) begin
              rx_st_reg <= ubt_pkg::RX_IDLE;
              if (rxd) begin
                rx_holding_reg <= rx_shift_reg;
              end
            end else begin
              rx_shift_reg <= {rxd, rx_shift_reg[7:1]};
              rx_bits_reg  <= rx_bits_reg - 4'h1;
            end
          end
        end
        default: rx_st_reg <= ubt_pkg::RX_IDLE;
      endcase
    end
  end

  // control and sticky status; hardware set beats software clear
  logic [ubt_pkg::ST_W-1:0] st_set;
  logic [ubt_pkg::ST_W-1:0] st_clr;
  always_comb begin
    st_set = '0;
    st_clr = wr_stat ? pwdata[ubt_pkg::ST_W-1:0] : '0;
    st_set[ubt_pkg::ST_TXE]   = te_rise | tx_load;
    st_set[ubt_pkg::ST_RXF]   = rx_good;
    st_set[ubt_pkg::ST_TEND]  = tx_end;
    st_set[ubt_pkg::ST_RERR]  = rx_done & (~rxd | stat_reg[ubt_pkg::ST_RXF]);
    st_set[ubt_pkg::ST_START] = sw_fall;
    st_clr[ubt_pkg::ST_TXE]   = st_clr[ubt_pkg::ST_TXE] | tx_go;
    st_clr[ubt_pkg::ST_RXF]   = st_clr[ubt_pkg::ST_RXF] | rx_go;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= ubt_pkg::ubt_ctrl_t'(ubt_pkg::CTRL_RST);
      stat_reg <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= ctrl_w;
      end
      stat_reg <= st_set | (stat_reg & ~st_clr);
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_tx_trigger;
    tx_go |=> hold_full_reg && tx_holding_reg == $past(tx_mem[txd_reg.ptr]);
  endproperty
  a_tx_trigger: assert property (p_tx_trigger) else $error("tx request did not load holding");

  property p_tx_ptr;
    tx_go && !wr_txd |=> txd_reg.ptr == $past(txd_reg.ptr) + 8'h01;
  endproperty
  a_tx_ptr: assert property (p_tx_ptr) else $error("tx pointer did not advance");

  property p_count;
    tx_go |=> txd_reg.cnt == $past(txd_reg.cnt) - 9'h001;
  endproperty
  a_count: assert property (p_count) else $error("tx count did not step");

  property p_exhausted;
    tx_req && txd_reg.cnt == 9'h0 && !tx_load |=> stat_reg[ubt_pkg::ST_TXE];
  endproperty
  a_exhausted: assert property (p_exhausted) else $error("event consumed with zero count");

  property p_te_rise;
    te_rise |=> stat_reg[ubt_pkg::ST_TXE];
  endproperty
  a_te_rise: assert property (p_te_rise) else $error("enable write did not raise tx empty");

  property p_tx_clear;
    tx_go && !tx_load && !te_rise |=> !stat_reg[ubt_pkg::ST_TXE];
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("tx pending not cleared by engine");

  property p_load;
    tx_load |=> !serial_out_pin && stat_reg[ubt_pkg::ST_TXE] ##1 !serial_out_pin;
  endproperty
  a_load: assert property (p_load) else $error("load did not start frame");

  property p_rx_full;
    rx_good |=> stat_reg[ubt_pkg::ST_RXF] && rx_holding_reg == $past(rx_shift_reg);
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("received byte not posted");

  property p_rx_clear;
    rx_go && !rx_good |=> !stat_reg[ubt_pkg::ST_RXF];
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rx pending not cleared by engine");

  property p_idle_high;
    !tx_busy_reg && !$past(tx_load) |-> serial_out_pin;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not idle high");

  property p_start;
    sw_fall |=> stat_reg[ubt_pkg::ST_START];
  endproperty
  a_start: assert property (p_start) else $error("start edge lost");
endmodule

// ---- ubt_peer.sv ----
// Purpose: remote serial peer facing the block's serial lines
// Assumes: 8 data bits lsb first, one stop bit, no parity, no flow control
// Notes:   line_out idles high, as a real uart driver holds it between frames
`timescale 1ns/1ns
module ubt_peer (
  // clock
  input  wire logic clk,
  // serial lines
  input  wire logic line_in,
  output logic      line_out
);
  logic [7:0] got [$];
  int         stop_errs = 0;
  logic [7:0] sh;

  initial line_out = 1'b1;

  // sample mid-bit: half a bit after the falling start edge, then whole bits
  initial begin
    forever begin
      @(negedge line_in);
      repeat (ubt_pkg::HALF_CYC) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (ubt_pkg::BIT_CYC) @(posedge clk);
        sh[i] = line_in;
      end
      repeat (ubt_pkg::BIT_CYC) @(posedge clk);
      if (line_in !== 1'b1) stop_errs++;
      got.push_back(sh);
    end
  end

  // stop=0 sends a broken frame on purpose
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] fr;
    fr = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= fr[i];
      repeat (ubt_pkg::BIT_CYC) @(posedge clk);
    end
    line_out <= 1'b1;
  endtask
endmodule

// ---- ubt_pkg.sv ----
// Purpose: shared constants and types for the serial block-transfer engine
// Assumes: 100 MHz clk, APB with 32-bit data
// Notes:   one aligned word per register, one word per buffer byte
package ubt_pkg;
  localparam int          CLK_HZ      = 100_000_000;
  localparam int          BAUD_BPS    = 38_400;
  // bit time rounds down to whole clk cycles
  localparam logic [11:0] BIT_CYC     = 12'(CLK_HZ / BAUD_BPS);
  localparam logic [11:0] HALF_CYC    = 12'(CLK_HZ / BAUD_BPS / 2);
  localparam logic [8:0]  BLOCK_LEN   = 9'h100;
  localparam logic [3:0]  FRAME_BITS  = 4'ha;
  localparam logic [3:0]  DATA_BITS   = 4'h8;
  // register byte addresses and buffer area selects
  localparam logic [11:0] CTRL_ADDR   = 12'h000;
  localparam logic [11:0] STAT_ADDR   = 12'h004;
  localparam logic [11:0] TXD_ADDR    = 12'h008;
  localparam logic [11:0] RXD_ADDR    = 12'h00c;
  localparam logic [11:0] HOLD_ADDR   = 12'h010;
  localparam logic [1:0]  TXBUF_SEL   = 2'h1;
  localparam logic [1:0]  RXBUF_SEL   = 2'h2;
  // status bit positions
  localparam int          ST_TXE      = 0;
  localparam int          ST_RXF      = 1;
  localparam int          ST_TEND     = 2;
  localparam int          ST_RERR     = 3;
  localparam int          ST_START    = 4;
  localparam int          ST_W        = 5;
  // descriptor fields and control reset value
  localparam int          DS_PTR_LSB  = 0;
  localparam int          DS_CNT_LSB  = 8;
  localparam int          DS_EN_BIT   = 31;
  localparam logic [5:0]  CTRL_RST    = 6'h00;

  typedef struct packed {
    logic err_ie;
    logic rx_on;
    logic transmitter_on;
    logic tx_done_int_enable;
    logic rx_full_int_enable;
    logic tx_empty_int_enable;
  } ubt_ctrl_t;

  typedef struct packed {
    logic       en;
    logic [8:0] cnt;
    logic [7:0] ptr;
  } ubt_desc_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10
  } ubt_rx_state_t;
endpackage
